// *** core/lpl_defs.svh ***
/*
 * Constants of the link-to-phy port: control codes, request codes, request frame layout.
 * Assumes inclusion by bare name from the package and the port module.
 */
`ifndef LPL_DEFS_SVH
`define LPL_DEFS_SVH

// Control codes while the phy owns the bus
`define LPL_CTL_IDLE 2'h0
`define LPL_CTL_STATUS 2'h1
`define LPL_CTL_RECV 2'h2
`define LPL_CTL_GRANT 2'h3
// Control codes while the link owns the bus
`define LPL_LCTL_IDLE 2'h0
`define LPL_LCTL_HOLD 2'h1
`define LPL_LCTL_SEND 2'h2
`define LPL_LCTL_RSVD 2'h3

// Request types
`define LPL_RQ_TAKE 3'h0
`define LPL_RQ_ISO 3'h1
`define LPL_RQ_PRIO 3'h2
`define LPL_RQ_FAIR 3'h3
`define LPL_RQ_REGRD 3'h4
`define LPL_RQ_REGWR 3'h5

// Request speeds
`define LPL_SPD_100 2'h0
`define LPL_SPD_200 2'h1
`define LPL_SPD_400 2'h2
`define LPL_SPD_RSVD 2'h3

// Frame lengths in bits, start and stop included
`define LPL_LEN_BUS 5'h07
`define LPL_LEN_RD 5'h09
`define LPL_LEN_WR 5'h11
// Frame field positions
`define LPL_FR_START 0
`define LPL_FR_TYPE 1
`define LPL_FR_SPEED 4
`define LPL_FR_ADDR 4
`define LPL_FR_DATA 8

`endif

// *** core/lpl_link_port.sv ***
/*
 * Link side of the link-to-phy port: request serialiser, bus ownership, transmit FIFO,
 * receive and status capture, cycle reference edge detect.
 * Assumes the phy interface clock and every phy pin arrive asynchronously to mclk,
 * with mclk at least twice as fast as the phy clock.
 */
`timescale 1ns/1ps
`include "lpl_defs.svh"

module lpl_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input wire logic mclk, // Clock
    input wire logic srst, // Sync reset
    input wire logic in_valid, // Write request
    output logic in_ready, // Room left
    input wire logic [W-1:0] in_data, // Write word
    output logic out_valid, // Word available
    input wire logic out_ready, // Pop
    output logic [W-1:0] out_data // Head word
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic room_reg, room_next, avail_reg, avail_next;
    logic push, pop;

    assign push = in_valid && room_reg;
    assign pop = out_ready && avail_reg;
    assign in_ready = room_reg;
    assign out_valid = avail_reg;
    assign out_data = mem[rd_reg];

    always_comb begin
        wr_next = push ? ((wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1) : wr_reg;
        rd_next = pop ? ((rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        room_next = cnt_next != (AW+1)'(D);
        avail_next = cnt_next != '0;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            room_reg <= 1'b1;
            avail_reg <= 1'b0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            room_reg <= room_next;
            avail_reg <= avail_next;
        end
    end

    // Storage has no reset; only words behind the pointers are ever read
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule : lpl_fifo

module lpl_link_port #(
    parameter int DW = 8,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk, // 125 MHz clock
    input wire logic srst, // Sync reset, active high
    input wire logic phy_sclk, // Phy interface clock, async
    input wire logic phy_ctl_bit_a_in, // Control bit a from pin
    output logic phy_ctl_bit_a_out, // Control bit a to pin
    output logic phy_ctl_bit_a_oe, // Control bit a enable
    input wire logic phy_ctl_bit_b_in, // Control bit b from pin
    output logic phy_ctl_bit_b_out, // Control bit b to pin
    output logic phy_ctl_bit_b_oe, // Control bit b enable
    input wire logic [DW-1:0] phy_data_bus_in, // Data from pins
    output logic [DW-1:0] phy_data_bus_out, // Data to pins
    output logic phy_data_bus_oe, // Data enable
    output logic link_request_line, // Serial request line
    input wire logic cycle_reference_input, // 125 us cycle reference, async
    output logic cycle_tick, // Pulse per cycle reference rise
    input wire logic req_valid, // Request offered
    output logic req_ready, // Serialiser free
    input wire lpl_pkg::lpl_rqtype_t req_type, // Request type
    input wire lpl_pkg::lpl_speed_t req_speed, // Request speed
    input wire logic [3:0] req_addr, // Phy register address
    input wire logic [7:0] req_wdata, // Phy register write data
    input wire logic tx_valid, // Transmit word offered
    output logic tx_ready, // FIFO has room
    input wire logic [DW-1:0] tx_data, // Transmit word
    input wire logic tx_last, // Last word of packet
    output logic rx_valid, // Receive word pulse
    output logic stat_valid, // Status word pulse
    output logic [DW-1:0] rx_data, // Received or status word
    output logic bus_owned // Link drives the bus
);
    import lpl_pkg::*;

    // Highest speed code the data bus width can carry
    localparam lpl_speed_t MAX_SPD = (DW >= 8) ? `LPL_SPD_400 : (DW >= 4) ? `LPL_SPD_200 : `LPL_SPD_100;

    logic sclk_s1, sclk_s2, sclk_s3;
    logic ctla_s1, ctla_s2, ctlb_s1, ctlb_s2;
    logic [DW-1:0] dat_s1, dat_s2;
    logic cyc_s1, cyc_s2, cyc_s3;
    logic sclk_rise;
    logic [1:0] ctl_code;

    lpl_state_t state_reg, state_next;
    logic [1:0] ctlo_reg, ctlo_next;
    logic oe_reg, oe_next;
    logic [DW-1:0] dout_reg, dout_next;
    logic rxv_reg, rxv_next, stv_reg, stv_next;
    logic [DW-1:0] rxd_reg, rxd_next;
    logic [16:0] sh_reg, sh_next;
    logic [4:0] idx_reg, idx_next, len_reg, len_next;
    logic busy_reg, busy_next, rdy_reg, rdy_next, rline_reg, rline_next;
    logic tick_reg, tick_next;
    logic accept, legal, pop;
    logic f_valid;
    logic [DW:0] f_data;

    // Edge detect reads only the second and third stages; pins sampled when the edge is seen
    assign sclk_rise = sclk_s2 && !sclk_s3;
    assign ctl_code = {ctla_s2, ctlb_s2};
    assign accept = req_valid && rdy_reg;
    assign legal = (req_type >= `LPL_RQ_REGRD) ? (req_type <= `LPL_RQ_REGWR)
                 : (req_speed != `LPL_SPD_RSVD) && (req_speed <= MAX_SPD);
    assign pop = (state_reg == LPL_ST_OWN) && sclk_rise && f_valid;

    lpl_fifo #(.W(DW + 1), .D(FIFO_DEPTH)) u_txq (
        .mclk(mclk),
        .srst(srst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data({tx_last, tx_data}),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );

    always_comb begin
        logic [16:0] fr;
        fr = 17'h0_0000;
        state_next = state_reg;
        ctlo_next = ctlo_reg;
        oe_next = oe_reg;
        dout_next = dout_reg;
        rxv_next = 1'b0;
        stv_next = 1'b0;
        rxd_next = rxd_reg;
        sh_next = sh_reg;
        idx_next = idx_reg;
        len_next = len_reg;
        busy_next = busy_reg;
        rline_next = rline_reg;
        tick_next = cyc_s2 && !cyc_s3;
        // Frame sent low bit first; each field goes most significant bit first
        fr[`LPL_FR_START] = 1'b1;
        for (int i = 0; i < 3; i++) begin
            fr[`LPL_FR_TYPE + i] = req_type[2 - i];
        end
        if (req_type >= `LPL_RQ_REGRD) begin
            for (int i = 0; i < 4; i++) begin
                fr[`LPL_FR_ADDR + i] = req_addr[3 - i];
            end
            if (req_type == `LPL_RQ_REGWR) begin
                for (int i = 0; i < 8; i++) begin
                    fr[`LPL_FR_DATA + i] = req_wdata[7 - i];
                end
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                fr[`LPL_FR_SPEED + i] = req_speed[1 - i];
            end
        end
        // Illegal requests are taken and dropped so the requester never hangs
        if (accept && legal) begin
            sh_next = fr;
            idx_next = 5'h00;
            busy_next = 1'b1;
            len_next = (req_type == `LPL_RQ_REGWR) ? `LPL_LEN_WR
                     : (req_type == `LPL_RQ_REGRD) ? `LPL_LEN_RD : `LPL_LEN_BUS;
        end else if (busy_reg && sclk_rise) begin
            rline_next = sh_reg[0];
            sh_next = {1'b0, sh_reg[16:1]};
            idx_next = idx_reg + 5'h01;
            busy_next = idx_reg != (len_reg - 5'h01);
        end
        // A dropped request leaves the serialiser free, so ready stays up
        rdy_next = !busy_next;
        if (sclk_rise) begin
            case (state_reg)
                LPL_ST_PHY: begin
                    case (ctl_code)
                        `LPL_CTL_STATUS: begin
                            stv_next = 1'b1;
                            rxd_next = dat_s2;
                        end
                        `LPL_CTL_RECV: begin
                            rxv_next = 1'b1;
                            rxd_next = dat_s2;
                        end
                        `LPL_CTL_GRANT: begin
                            state_next = LPL_ST_OWN;
                            oe_next = 1'b1;
                            ctlo_next = `LPL_LCTL_HOLD;
                            dout_next = '0;
                        end
                        default: begin
                        end
                    endcase
                end
                LPL_ST_OWN: begin
                    // An empty queue mid-packet holds the bus rather than giving it up
                    if (f_valid) begin
                        ctlo_next = `LPL_LCTL_SEND;
                        dout_next = f_data[DW-1:0];
                        if (f_data[DW]) begin
                            state_next = LPL_ST_END;
                        end
                    end else begin
                        ctlo_next = `LPL_LCTL_HOLD;
                        dout_next = '0;
                    end
                end
                LPL_ST_END: begin
                    ctlo_next = `LPL_LCTL_IDLE;
                    dout_next = '0;
                    state_next = LPL_ST_REL;
                end
                LPL_ST_REL: begin
                    oe_next = 1'b0;
                    state_next = LPL_ST_PHY;
                end
                default: begin
                    state_next = LPL_ST_PHY;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            {sclk_s1, sclk_s2, sclk_s3, ctla_s1, ctla_s2, ctlb_s1, ctlb_s2} <= 7'h00;
            {cyc_s1, cyc_s2, cyc_s3} <= 3'h0;
            dat_s1 <= '0;
            dat_s2 <= '0;
            state_reg <= LPL_ST_PHY;
            ctlo_reg <= `LPL_LCTL_IDLE;
            oe_reg <= 1'b0;
            dout_reg <= '0;
            rxv_reg <= 1'b0;
            stv_reg <= 1'b0;
            rxd_reg <= '0;
            sh_reg <= 17'h0_0000;
            idx_reg <= 5'h00;
            len_reg <= `LPL_LEN_BUS;
            busy_reg <= 1'b0;
            rdy_reg <= 1'b0;
            rline_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            {sclk_s1, sclk_s2, sclk_s3} <= {phy_sclk, sclk_s1, sclk_s2};
            {ctla_s1, ctla_s2, ctlb_s1, ctlb_s2} <= {phy_ctl_bit_a_in, ctla_s1, phy_ctl_bit_b_in, ctlb_s1};
            {cyc_s1, cyc_s2, cyc_s3} <= {cycle_reference_input, cyc_s1, cyc_s2};
            dat_s1 <= phy_data_bus_in;
            dat_s2 <= dat_s1;
            state_reg <= state_next;
            ctlo_reg <= ctlo_next;
            oe_reg <= oe_next;
            dout_reg <= dout_next;
            rxv_reg <= rxv_next;
            stv_reg <= stv_next;
            rxd_reg <= rxd_next;
            sh_reg <= sh_next;
            idx_reg <= idx_next;
            len_reg <= len_next;
            busy_reg <= busy_next;
            rdy_reg <= rdy_next;
            rline_reg <= rline_next;
            tick_reg <= tick_next;
        end
    end

    // Both control bits share one enable so the width never depends on speed
    assign phy_ctl_bit_a_out = ctlo_reg[1];
    assign phy_ctl_bit_b_out = ctlo_reg[0];
    assign phy_ctl_bit_a_oe = oe_reg;
    assign phy_ctl_bit_b_oe = oe_reg;
    assign phy_data_bus_out = dout_reg;
    assign phy_data_bus_oe = oe_reg;
    assign link_request_line = rline_reg;
    assign cycle_tick = tick_reg;
    assign req_ready = rdy_reg;
    assign rx_valid = rxv_reg;
    assign stat_valid = stv_reg;
    assign rx_data = rxd_reg;
    assign bus_owned = oe_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_oe_after_grant: assert property ($rose(oe_reg) |-> $past(sclk_rise && ctl_code == `LPL_CTL_GRANT))
        else $error("Bus driven without grant");
    a_grant_taken: assert property (state_reg == LPL_ST_PHY && sclk_rise && ctl_code == `LPL_CTL_GRANT
        |=> oe_reg && ctlo_reg == `LPL_LCTL_HOLD)
        else $error("Grant not taken");
    a_no_reserved_code: assert property (oe_reg |-> ctlo_reg != `LPL_LCTL_RSVD)
        else $error("Reserved control code driven");
    a_release_after_idle: assert property ($fell(oe_reg) |-> $past(ctlo_reg) == `LPL_LCTL_IDLE)
        else $error("Bus released without idle code");
    a_start_bit_one: assert property (busy_reg && sclk_rise && idx_reg == 5'h00 |=> rline_reg)
        else $error("Start bit not one");
    a_stop_bit_zero: assert property (busy_reg && sclk_rise && idx_reg == len_reg - 5'h01
        |=> !rline_reg && !busy_reg)
        else $error("Stop bit missing");
    a_len_by_type: assert property (accept && legal
        |=> busy_reg && len_reg == (($past(req_type) == `LPL_RQ_REGWR)
        ? `LPL_LEN_WR : ($past(req_type) == `LPL_RQ_REGRD) ? `LPL_LEN_RD : `LPL_LEN_BUS))
        else $error("Frame length wrong for type");
    a_speed_reserved: assert property (accept && req_type < `LPL_RQ_REGRD && req_speed == `LPL_SPD_RSVD
        |=> !busy_reg)
        else $error("Reserved speed sent");
    a_line_on_edge: assert property ($changed(rline_reg) |-> $past(sclk_rise))
        else $error("Request line moved off phy edge");
    a_rx_capture: assert property (state_reg == LPL_ST_PHY && sclk_rise && ctl_code == `LPL_CTL_RECV
        |=> rx_valid && rx_data == $past(dat_s2))
        else $error("Receive word lost");
    a_idle_quiet: assert property (state_reg == LPL_ST_PHY && sclk_rise && ctl_code == `LPL_CTL_IDLE
        |=> !rx_valid && !stat_valid && !oe_reg)
        else $error("Activity on idle code");

    c_grant: cover property (state_reg == LPL_ST_OWN ##[1:200] state_reg == LPL_ST_PHY);
    c_receive: cover property (rx_valid ##[1:20] rx_valid);
    c_status: cover property (stat_valid);
    c_write_req: cover property (accept && legal && req_type == `LPL_RQ_REGWR ##[1:600] !busy_reg);
endmodule : lpl_link_port

// *** core/lpl_pkg.sv ***
/*
 * Types shared by the link-to-phy port.
 * Assumes lpl_defs.svh on the include path.
 */
`include "lpl_defs.svh"

package lpl_pkg;
    typedef enum logic [1:0] {
        LPL_ST_PHY = 2'b00,
        LPL_ST_OWN = 2'b01,
        LPL_ST_END = 2'b10,
        LPL_ST_REL = 2'b11
    } lpl_state_t;

    typedef logic [2:0] lpl_rqtype_t;
    typedef logic [1:0] lpl_speed_t;
endpackage : lpl_pkg

// *** tb/lpl_phy_model.sv ***
/*
 * Behavioural phy: free-running interface clock, control codes, request and transmit capture.
 * Assumes the bench resolves each shared line from both enables.
 */
`timescale 1ns/1ps
module lpl_phy_model #(
    parameter int LAUNCH = 30 // Launch delay after sclk rise
) (
    output logic sclk, // Interface clock
    input wire logic rq_line, // Request line
    input wire logic l_oe, // Link drives control
    input wire logic [1:0] ctl_w, // Control wire
    input wire logic [7:0] data_w, // Data wire
    output logic [1:0] ctl, // Control driven
    output logic [7:0] data, // Data driven
    output logic en // Phy drives shared lines
);
    logic [16:0] sh = '0;
    logic [16:0] last_frame = '0;
    logic [7:0] words [0:15];
    logic saw_rel = 1'b0;
    int n = 0;
    int len = 7;
    int frames = 0;
    int nw = 0;
    initial begin
        sclk = 1'b0;
        forever #32 sclk = ~sclk;
    end
    initial begin
        en = 1'b1;
        ctl = 2'h0;
        data = 8'h00;
    end
    // Late launch: the link samples the pins within one mclk after each rise
    always @(posedge sclk) begin
        if (n == 0) begin
            if (rq_line === 1'b1) begin
                sh = 17'h0_0001;
                n = 1;
            end
        end else begin
            sh = {sh[15:0], rq_line};
            n++;
            if (n == 4) len = (sh[2:0] == 3'h4) ? 9 : (sh[2:0] == 3'h5) ? 17 : 7;
            if (n == len) begin
                last_frame = sh;
                frames++;
                n = 0;
            end
        end
        if (l_oe === 1'b1 && ctl_w == 2'h2) begin
            words[nw[3:0]] = data_w;
            nw++;
        end
        if (l_oe === 1'b1 && ctl_w == 2'h0) saw_rel = 1'b1;
    end
    // Take the lines back the moment the link lets go
    always @(negedge l_oe) begin
        ctl = 2'h0;
        en = 1'b1;
    end
    task send(input logic [1:0] code, input logic [7:0] d);
        @(posedge sclk);
        #LAUNCH;
        ctl = code;
        data = d;
        @(posedge sclk);
        #LAUNCH;
        ctl = 2'h0;
    endtask : send
    task grant;
        int i;
        @(posedge sclk);
        #LAUNCH;
        ctl = 2'h3;
        @(posedge sclk);
        #LAUNCH;
        en = 1'b0;
        i = 0;
        while (l_oe !== 1'b1 && i < 8) begin
            @(posedge sclk);
            i++;
        end
        while (l_oe === 1'b1 && i < 64) begin
            @(posedge sclk);
            i++;
        end
    endtask : grant
endmodule : lpl_phy_model

// *** tb/testbench.sv ***
/*
 * Self-checking bench of the link port with the phy model.
 * Assumes the design files compiled first.
 */
`timescale 1ns/1ps
`include "lpl_defs.svh"
module testbench;
    import lpl_pkg::*;
    logic mclk, srst, cri, req_valid, tx_valid, tx_last;
    lpl_rqtype_t req_type;
    lpl_speed_t req_speed;
    logic [3:0] req_addr;
    logic [7:0] req_wdata, tx_data, d_out, rx_data, p_data, data_w, rx_last;
    logic a_out, a_oe, b_out, b_oe, d_oe, rq_line, tick, req_ready, tx_ready, rx_valid, stat_valid, bus_owned;
    logic sclk, p_en;
    logic [1:0] p_ctl, ctl_w;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rx_cnt = 0;
    int st_cnt = 0;
    int tick_cnt = 0;
    // Undriven lines show the inverse of the last value
    assign ctl_w[1] = a_oe ? a_out : (p_en ? p_ctl[1] : ~p_ctl[1]);
    assign ctl_w[0] = b_oe ? b_out : (p_en ? p_ctl[0] : ~p_ctl[0]);
    assign data_w = d_oe ? d_out : (p_en ? p_data : ~p_data);
    lpl_link_port #(.DW(8), .FIFO_DEPTH(8)) uut (.mclk(mclk), .srst(srst), .phy_sclk(sclk),
        .phy_ctl_bit_a_in(ctl_w[1]), .phy_ctl_bit_a_out(a_out), .phy_ctl_bit_a_oe(a_oe),
        .phy_ctl_bit_b_in(ctl_w[0]), .phy_ctl_bit_b_out(b_out), .phy_ctl_bit_b_oe(b_oe),
        .phy_data_bus_in(data_w), .phy_data_bus_out(d_out), .phy_data_bus_oe(d_oe), .link_request_line(rq_line),
        .cycle_reference_input(cri), .cycle_tick(tick), .req_valid(req_valid), .req_ready(req_ready),
        .req_type(req_type), .req_speed(req_speed), .req_addr(req_addr), .req_wdata(req_wdata),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid),
        .stat_valid(stat_valid), .rx_data(rx_data), .bus_owned(bus_owned));
    lpl_phy_model phy (.sclk(sclk), .rq_line(rq_line), .l_oe(a_oe), .ctl_w(ctl_w), .data_w(data_w),
        .ctl(p_ctl), .data(p_data), .en(p_en));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (rx_valid === 1'b1) begin
            rx_cnt++;
            rx_last = rx_data;
        end
        if (stat_valid === 1'b1) begin
            st_cnt++;
            rx_last = rx_data;
        end
        if (tick === 1'b1) tick_cnt++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task t_reset;
        repeat (8) @(negedge mclk);
        check("oe_in_reset", {a_oe, b_oe, d_oe}, 32'h0);
        check("ready_in_reset", req_ready, 32'h0);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        check("ready_after", req_ready, 32'h1);
        check("owned_idle", bus_owned, 32'h0);
    endtask : t_reset
    // len 0 marks a request that must be dropped
    task do_req(input logic [2:0] t, input logic [1:0] s, input logic [3:0] a, input logic [7:0] d,
                input logic [16:0] exp, input int len);
        int f0;
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 400) begin
            @(negedge mclk);
            i++;
        end
        f0 = phy.frames;
        req_valid = 1'b1;
        req_type = t;
        req_speed = s;
        req_addr = a;
        req_wdata = d;
        @(negedge mclk);
        req_valid = 1'b0;
        check("ready_after_take", req_ready, (len == 0));
        repeat (400) @(negedge mclk);
        check("frame_count", phy.frames - f0, (len != 0));
        if (len != 0) check("frame_bits", phy.last_frame, exp);
    endtask : do_req
    task t_requests;
        for (int k = 0; k < 4; k++) begin
            do_req(k[2:0], k[1:0] % 2'h3, 4'h0, 8'h00, {10'h000, 1'b1, k[2:0], k[1:0] % 2'h3, 1'b0}, 7);
        end
        do_req(`LPL_RQ_REGRD, 2'h0, 4'hA, 8'h00, {8'h00, 1'b1, `LPL_RQ_REGRD, 4'hA, 1'b0}, 9);
        do_req(`LPL_RQ_REGWR, 2'h0, 4'h5, 8'hC3, {1'b1, `LPL_RQ_REGWR, 4'h5, 8'hC3, 1'b0}, 17);
        do_req(3'h6, 2'h0, 4'h0, 8'h00, 17'h0_0000, 0);
        do_req(3'h7, 2'h0, 4'h0, 8'h00, 17'h0_0000, 0);
        do_req(`LPL_RQ_FAIR, `LPL_SPD_RSVD, 4'h0, 8'h00, 17'h0_0000, 0);
    endtask : t_requests
    task t_receive;
        phy.send(`LPL_CTL_RECV, 8'h5A);
        repeat (8) @(negedge mclk);
        check("rx_pulses", rx_cnt, 32'h1);
        check("rx_word", rx_last, 32'h5A);
        phy.send(`LPL_CTL_STATUS, 8'hA5);
        repeat (8) @(negedge mclk);
        check("stat_pulses", st_cnt, 32'h1);
        check("stat_word", rx_last, 32'hA5);
        phy.send(`LPL_CTL_IDLE, 8'h3C);
        repeat (8) @(negedge mclk);
        check("idle_quiet", rx_cnt + st_cnt, 32'h2);
        check("owned_rx", bus_owned, 32'h0);
    endtask : t_receive
    task t_transmit;
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            tx_valid = 1'b1;
            tx_data = i[7:0] + 8'h20;
            tx_last = (i == 7);
        end
        @(negedge mclk);
        tx_valid = 1'b0;
        tx_last = 1'b0;
        // No grant yet: the buffer must neither drain nor take the bus
        repeat (40) @(negedge mclk);
        check("tx_full", tx_ready, 32'h0);
        check("owned_stall", bus_owned, 32'h0);
        phy.grant;
        check("tx_count", phy.nw, 32'h8);
        for (int i = 0; i < 8; i++) check("tx_word", phy.words[i], i + 32'h20);
        check("tx_release", phy.saw_rel, 32'h1);
        @(negedge mclk);
        check("owned_after", bus_owned, 32'h0);
        check("tx_empty", tx_ready, 32'h1);
    endtask : t_transmit
    // One full 125 us reference period, both phases above 62 us
    task t_cycle;
        tick_cnt = 0;
        @(negedge mclk);
        // Each phase is 7813 cycles, so the period is 125.008 us and edges stay on falling mclk
        cri = 1'b1;
        repeat (7813) @(negedge mclk);
        cri = 1'b0;
        repeat (7813) @(negedge mclk);
        check("cycle_ticks", tick_cnt, 32'h1);
    endtask : t_cycle
    initial begin
        srst = 1'b1;
        cri = 1'b0;
        req_valid = 1'b0;
        req_type = 3'h0;
        req_speed = 2'h0;
        req_addr = 4'h0;
        req_wdata = 8'h00;
        tx_valid = 1'b0;
        tx_last = 1'b0;
        tx_data = 8'h00;
        t_reset;
        t_requests;
        t_receive;
        t_transmit;
        t_cycle;
        tally_and_finish;
    end
endmodule : testbench
